// *** src/bts_pkg.sv ***
package bts_pkg;

  // Clock and timing.
  localparam int CLK_HZ     = 10_000_000;
  localparam int STEP_MS    = 10;
  localparam int STEP_CYC   = CLK_HZ / 1000 * STEP_MS;
  localparam int RATE_STD   = 12000;
  localparam int RATE_ALT   = 11025;
  localparam int SR_DIV_STD = CLK_HZ / RATE_STD;
  localparam int SR_DIV_ALT = CLK_HZ / RATE_ALT;
  localparam int PHASE_FULL = 65536;

  // Register indices; the byte address is four times the index.
  localparam logic [9:0] IDX_CFG1      = 10'h0a0;
  localparam logic [9:0] IDX_CFG2      = 10'h0a1;
  localparam logic [9:0] IDX_F1_LO     = 10'h0a2;
  localparam logic [9:0] IDX_F1_HI     = 10'h0a3;
  localparam logic [9:0] IDX_F2_LO     = 10'h0a4;
  localparam logic [9:0] IDX_F2_HI     = 10'h0a5;
  localparam logic [9:0] IDX_REPEAT    = 10'h0a6;
  localparam logic [9:0] IDX_ON_TIME   = 10'h0a7;
  localparam logic [9:0] IDX_OFF_TIME  = 10'h0a8;
  localparam logic [9:0] IDX_RATE      = 10'h0a9;
  localparam logic [9:0] IDX_STATUS    = 10'h0aa;

  // Reset values.
  localparam logic [7:0] RST_F1_LO    = 8'h55;
  localparam logic [7:0] RST_F1_HI    = 8'h15;
  localparam logic [7:0] RST_F2_LO    = 8'h00;
  localparam logic [7:0] RST_F2_HI    = 8'h40;
  localparam logic [2:0] RST_REPEAT   = 3'h0;
  localparam logic [5:0] RST_ON_TIME  = 6'h02;
  localparam logic [5:0] RST_OFF_TIME = 6'h01;

  // Field positions.
  localparam int RUN_BIT    = 7;
  localparam int KEY_EN_BIT = 4;
  localparam int BUSY_BIT   = 7;
  localparam int TONE_BIT   = 6;

  // Duration and repeat encodings.
  localparam logic [5:0] CODE_CONT       = 6'h3f;
  localparam logic [5:0] CODE_FINE_MAX   = 6'h18;
  localparam logic [5:0] CODE_COARSE_MIN = 6'h19;
  localparam logic [8:0] COARSE_BASE     = 9'h019;
  localparam logic [8:0] COARSE_STEP     = 9'h005;
  localparam logic [2:0] REPEAT_INF      = 3'h7;

  // Output selector codes.
  localparam logic [1:0] OUT_SUM  = 2'h0;
  localparam logic [1:0] OUT_ONE  = 2'h1;
  localparam logic [1:0] OUT_TWO  = 2'h2;
  localparam logic [1:0] OUT_RAMP = 2'h3;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Keypad row frequencies, then column frequencies, in Hz.
  localparam int DTMF_F [8] = '{697, 770, 852, 941, 1209, 1336, 1477, 1633};

  typedef enum logic [1:0] {ST_IDLE, ST_ON, ST_OFF} bts_state_e;

  function automatic logic [15:0] bts_word(input int f, input int rate);
    return 16'((f * PHASE_FULL) / rate - 1);
  endfunction

  // Step word of a keypad tone; col selects the column tone.
  function automatic logic [15:0] bts_dtmf_step(input logic [3:0] key, input logic alt,
                                                input logic col);
    logic [1:0]  row_i;
    logic [1:0]  col_i;
    logic [2:0]  sel;
    logic [15:0] ret;
    case (key)
      4'h1, 4'h2, 4'h3, 4'ha: row_i = 2'h0;
      4'h4, 4'h5, 4'h6, 4'hb: row_i = 2'h1;
      4'h7, 4'h8, 4'h9, 4'hc: row_i = 2'h2;
      default:                row_i = 2'h3;
    endcase
    case (key)
      4'h1, 4'h4, 4'h7, 4'he: col_i = 2'h0;
      4'h2, 4'h5, 4'h8, 4'h0: col_i = 2'h1;
      4'h3, 4'h6, 4'h9, 4'hf: col_i = 2'h2;
      default:                col_i = 2'h3;
    endcase
    sel = col ? {1'b1, col_i} : {1'b0, row_i};
    ret = 16'h0000;
    for (int k = 0; k < 8; k++)
    begin
      if (sel == 3'(k))
        ret = alt ? bts_word(DTMF_F[k], RATE_ALT) : bts_word(DTMF_F[k], RATE_STD);
    end
    return ret;
  endfunction

endpackage

// *** src/bts_tone_if.sv ***
`timescale 1ns/100ps
`default_nettype none
interface bts_tone_if;
  logic        [15:0] step;
  logic               run;
  logic               tick;
  logic signed [15:0] sine;
  logic signed [15:0] cosine;
  logic               zero_cross;

  modport gen (input step, input run, input tick, output sine, output cosine,
               output zero_cross);
  modport ctl (output step, output run, output tick, input sine, input cosine,
               input zero_cross);
endinterface
`default_nettype wire

// *** src/bts_tone_gen.sv ***
`timescale 1ns/100ps
`default_nettype none
module bts_tone_gen
  import bts_pkg::*;
(
  input wire logic aclk,    // System clock.
  input wire logic aresetn, // Synchronous reset, active low.
  bts_tone_if.gen  tone     // Step word in, samples out.
);

  logic [15:0] phase;
  logic [15:0] next_phase;

  function automatic logic [14:0] quarter(input logic [3:0] i);
    case (i)
      4'h0: return 15'd0;
      4'h1: return 15'd3212;
      4'h2: return 15'd6393;
      4'h3: return 15'd9512;
      4'h4: return 15'd12539;
      4'h5: return 15'd15446;
      4'h6: return 15'd18204;
      4'h7: return 15'd20787;
      4'h8: return 15'd23170;
      4'h9: return 15'd25329;
      4'ha: return 15'd27245;
      4'hb: return 15'd28898;
      4'hc: return 15'd30273;
      4'hd: return 15'd31356;
      4'he: return 15'd32137;
      default: return 15'd32609;
    endcase
  endfunction

  function automatic logic signed [15:0] sine_of(input logic [15:0] p);
    logic [14:0] mag;
    mag = p[14] ? quarter(~p[13:10]) : quarter(p[13:10]);
    return p[15] ? -$signed({1'b0, mag}) : $signed({1'b0, mag});
  endfunction

  // The stored word is one less than the true phase step.
  assign next_phase = phase + tone.step + 16'h0001; // R1 R2

  // A stopped generator rests at phase zero, so every tone starts on a crossing.
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !tone.run)
    begin
      phase           <= 16'h0000;
      tone.sine       <= 16'sh0000;
      tone.cosine     <= 16'sh7fff;
      tone.zero_cross <= 1'b0;
    end
    else if (tone.tick)
    begin
      phase           <= next_phase;
      tone.sine       <= sine_of(next_phase);
      tone.cosine     <= sine_of(next_phase + 16'h4000);
      tone.zero_cross <= next_phase[15] != phase[15];
    end
    else
    begin
      tone.zero_cross <= 1'b0;
    end
  end

endmodule // bts_tone_gen
`default_nettype wire

// *** src/bts_beep_tone_sequencer.sv ***
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// [R1] Second step word, 12 kHz family scaling
// [R2] 11.025 kHz family scales against 11025
// [R3] Repeat codes give 1,2,3,4,8,16,32 beeps
// [R4] Repeat code 111 runs until stopped
// [R5] On codes 0x1-0x14: 10 ms steps
// [R6] Codes 0x15-0x18 reserved, undefined duration
// [R7] Codes 0x19-0x3C: 250 ms, 50 ms steps
// [R8] Code 0x3F sounds continuously
// [R9] Off-period uses the same encoding
// [R10] Reset: on code 0x2, off code 0x1
// [R11] Cycle is on then off, counted
// [R12] Step word is high byte, low byte
// [R13] Writing run starts; cleared when done
// [R14] Run cleared: stop after cycle or crossing
// [R15] Keypad select derives both tones
// [R16] Selector picks sum, one, two, ramp
module bts_beep_tone_sequencer
  import bts_pkg::*;
#(
  parameter int STEP_CYCLES = STEP_CYC // Clock cycles in one 10 ms step.
)
(
  input  wire logic        aclk,          // System clock, 10 MHz.
  input  wire logic        aresetn,       // Synchronous reset, active low.
  input  wire logic [11:0] s_axi_awaddr,  // Write address.
  input  wire logic        s_axi_awvalid, // Write address valid.
  output logic             s_axi_awready, // Write address ready.
  input  wire logic [31:0] s_axi_wdata,   // Write data.
  input  wire logic [3:0]  s_axi_wstrb,   // Write byte strobes.
  input  wire logic        s_axi_wvalid,  // Write data valid.
  output logic             s_axi_wready,  // Write data ready.
  output logic [1:0]       s_axi_bresp,   // Write response.
  output logic             s_axi_bvalid,  // Write response valid.
  input  wire logic        s_axi_bready,  // Write response ready.
  input  wire logic [11:0] s_axi_araddr,  // Read address.
  input  wire logic        s_axi_arvalid, // Read address valid.
  output logic             s_axi_arready, // Read address ready.
  output logic [31:0]      s_axi_rdata,   // Read data.
  output logic [1:0]       s_axi_rresp,   // Read response.
  output logic             s_axi_rvalid,  // Read data valid.
  input  wire logic        s_axi_rready,  // Read data ready.
  output logic [15:0]      audio_sample,  // Tone sample for the mixer.
  output logic             audio_valid,   // One-cycle pulse per sample.
  output logic             tone_active    // High during the on-phase.
);

  localparam int STEP_W = $clog2(STEP_CYCLES + 1);

  // Register storage.
  logic              run_req;
  logic              key_en;
  logic [3:0]        key_digit;
  logic [1:0]        out_sel;
  logic [7:0]        first_tone_step_low;
  logic [7:0]        first_tone_step_high;
  logic [7:0]        second_tone_step_low;
  logic [7:0]        second_tone_step_high;
  logic [2:0]        repeat_code;
  logic [5:0]        on_code;
  logic [5:0]        off_code;
  logic              rate_alt;

  // Bus side.
  logic [9:0]        aw_idx;
  logic              aw_aligned;
  logic [7:0]        w_byte;
  logic              w_lane0;
  logic              wr_fire;
  logic              wr_map;
  logic              wr_en;
  logic              rd_map;
  logic [7:0]        rd_byte;
  logic [9:0]        ar_idx;

  // Sequencer.
  bts_state_e        state;
  logic [5:0]        cycles_done;
  logic [8:0]        ticks;
  logic [8:0]        on_len;
  logic [8:0]        off_len;
  logic [5:0]        repeat_total;
  logic [STEP_W-1:0] step_cnt;
  logic              step_tick;
  logic              on_end;
  logic              off_end;
  logic              last_cycle;
  logic              seq_done;
  logic [9:0]        sr_cnt;
  logic [9:0]        sr_div;
  logic              sample_en;
  logic signed [15:0] mix_sum;
  logic signed [16:0] ramp_w;

  bts_tone_if tone1 ();
  bts_tone_if tone2 ();

  function automatic logic [8:0] dur_ticks(input logic [5:0] code);
    if (code == 6'h00)
      return 9'h001;
    else if (code <= CODE_FINE_MAX)
      return {3'h0, code}; // R5 R6
    else
      return COARSE_BASE + 9'(code - CODE_COARSE_MIN) * COARSE_STEP; // R7
  endfunction

  function automatic logic [5:0] repeat_of(input logic [2:0] code);
    case (code)
      3'h4:    return 6'd8;
      3'h5:    return 6'd16;
      3'h6:    return 6'd32;
      default: return 6'({1'b0, code[1:0]}) + 6'd1;
    endcase
  endfunction

  // Write channel: address and data are taken in either order.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b1;
      aw_idx        <= 10'h000;
      aw_aligned    <= 1'b0;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      s_axi_awready <= 1'b0;
      aw_idx        <= s_axi_awaddr[11:2];
      aw_aligned    <= s_axi_awaddr[1:0] == 2'h0;
    end
    else if (s_axi_bvalid && s_axi_bready)
    begin
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_wready <= 1'b1;
      w_byte       <= 8'h00;
      w_lane0      <= 1'b0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      s_axi_wready <= 1'b0;
      w_byte       <= s_axi_wdata[7:0];
      w_lane0      <= s_axi_wstrb[0];
    end
    else if (s_axi_bvalid && s_axi_bready)
    begin
      s_axi_wready <= 1'b1;
    end
  end

  assign wr_fire = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  assign wr_map  = aw_aligned && aw_idx >= IDX_CFG1 && aw_idx <= IDX_STATUS;
  assign wr_en   = wr_fire && wr_map && w_lane0;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end
    else if (wr_fire)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_map ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_bready)
    begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Configuration registers.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      key_en                <= 1'b0;
      key_digit             <= 4'h0;
      out_sel               <= OUT_SUM;
      first_tone_step_low   <= RST_F1_LO;
      first_tone_step_high  <= RST_F1_HI;
      second_tone_step_low  <= RST_F2_LO;
      second_tone_step_high <= RST_F2_HI; // R1
      repeat_code           <= RST_REPEAT;
      on_code               <= RST_ON_TIME; // R10
      off_code              <= RST_OFF_TIME; // R10
      rate_alt              <= 1'b0;
    end
    else if (wr_en)
    begin
      if (aw_idx == IDX_CFG1)
      begin
        key_en    <= w_byte[KEY_EN_BIT];
        key_digit <= w_byte[3:0];
      end
      else if (aw_idx == IDX_CFG2)
        out_sel <= w_byte[1:0];
      else if (aw_idx == IDX_F1_LO)
        first_tone_step_low <= w_byte;
      else if (aw_idx == IDX_F1_HI)
        first_tone_step_high <= w_byte;
      else if (aw_idx == IDX_F2_LO)
        second_tone_step_low <= w_byte;
      else if (aw_idx == IDX_F2_HI)
        second_tone_step_high <= w_byte; // R1
      else if (aw_idx == IDX_REPEAT)
        repeat_code <= w_byte[2:0];
      else if (aw_idx == IDX_ON_TIME)
        on_code <= w_byte[5:0];
      else if (aw_idx == IDX_OFF_TIME)
        off_code <= w_byte[5:0]; // R9
      else if (aw_idx == IDX_RATE)
        rate_alt <= w_byte[0]; // R2
    end
  end

  // A software write in the same cycle as the self-clear wins.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      run_req <= 1'b0;
    else if (wr_en && aw_idx == IDX_CFG1)
      run_req <= w_byte[RUN_BIT]; // R13
    else if (seq_done)
      run_req <= 1'b0; // R13
  end

  // Read channel.
  assign ar_idx = s_axi_araddr[11:2];
  assign rd_map = s_axi_araddr[1:0] == 2'h0 && ar_idx >= IDX_CFG1 && ar_idx <= IDX_STATUS;

  always_comb
  begin
    rd_byte = 8'h00;
    if (ar_idx == IDX_CFG1)
      rd_byte = {run_req, 2'h0, key_en, key_digit};
    else if (ar_idx == IDX_CFG2)
      rd_byte = {6'h00, out_sel};
    else if (ar_idx == IDX_F1_LO)
      rd_byte = first_tone_step_low;
    else if (ar_idx == IDX_F1_HI)
      rd_byte = first_tone_step_high;
    else if (ar_idx == IDX_F2_LO)
      rd_byte = second_tone_step_low;
    else if (ar_idx == IDX_F2_HI)
      rd_byte = second_tone_step_high;
    else if (ar_idx == IDX_REPEAT)
      rd_byte = {5'h00, repeat_code};
    else if (ar_idx == IDX_ON_TIME)
      rd_byte = {2'h0, on_code};
    else if (ar_idx == IDX_OFF_TIME)
      rd_byte = {2'h0, off_code};
    else if (ar_idx == IDX_RATE)
      rd_byte = {7'h00, rate_alt};
    else if (ar_idx == IDX_STATUS)
      rd_byte = {state != ST_IDLE, state == ST_ON, cycles_done};
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= {24'h00_0000, rd_map ? rd_byte : 8'h00};
      s_axi_rresp   <= rd_map ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
    end
  end

  // Sample-rate enable; the divider is chosen by the rate family.
  assign sr_div = rate_alt ? 10'(SR_DIV_ALT) : 10'(SR_DIV_STD); // R1 R2

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sr_cnt    <= 10'h000;
      sample_en <= 1'b0;
    end
    else if (sr_cnt >= sr_div - 10'h001)
    begin
      sr_cnt    <= 10'h000;
      sample_en <= 1'b1;
    end
    else
    begin
      sr_cnt    <= sr_cnt + 10'h001;
      sample_en <= 1'b0;
    end
  end

  // Step divider restarts with each phase so durations are exact.
  assign step_tick = step_cnt == STEP_W'(STEP_CYCLES - 1);

  always_ff @(posedge aclk)
  begin
    if (!aresetn || state == ST_IDLE || on_end || off_end || step_tick)
      step_cnt <= '0;
    else
      step_cnt <= step_cnt + STEP_W'(1);
  end

  assign on_len       = dur_ticks(on_code); // R5 R7
  assign off_len      = dur_ticks(off_code); // R9
  assign repeat_total = repeat_of(repeat_code); // R3
  assign on_end  = state == ST_ON && on_code != CODE_CONT && step_tick
                   && ticks + 9'h001 >= on_len; // R8
  assign off_end = state == ST_OFF && off_code != CODE_CONT && step_tick
                   && ticks + 9'h001 >= off_len; // R9
  assign last_cycle = !run_req
                      || (repeat_code != REPEAT_INF && cycles_done + 6'h01 >= repeat_total); // R4

  // Beep sequencer: on-phase, then off-phase, then count the cycle.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state       <= ST_IDLE;
      ticks       <= 9'h000;
      cycles_done <= 6'h00;
      seq_done    <= 1'b0;
    end
    else
    begin
      seq_done <= 1'b0;
      case (state)
        ST_IDLE:
        begin
          ticks <= 9'h000;
          if (run_req && !seq_done)
          begin
            state       <= ST_ON; // R13
            cycles_done <= 6'h00;
          end
        end
        ST_ON:
        begin
          if (on_code == CODE_CONT && !run_req && tone1.zero_cross)
          begin
            state    <= ST_IDLE; // R14
            seq_done <= 1'b1;
          end
          else if (on_end)
          begin
            state <= ST_OFF; // R11
            ticks <= 9'h000;
          end
          else if (step_tick)
            ticks <= ticks + 9'h001;
        end
        ST_OFF:
        begin
          if (off_code == CODE_CONT && !run_req)
          begin
            state    <= ST_IDLE; // R14
            seq_done <= 1'b1;
          end
          else if (off_end)
          begin
            ticks       <= 9'h000;
            cycles_done <= cycles_done + 6'h01; // R11
            if (last_cycle)
            begin
              state    <= ST_IDLE; // R13 R14
              seq_done <= 1'b1;
            end
            else
              state <= ST_ON; // R4 R11
          end
          else if (step_tick)
            ticks <= ticks + 9'h001;
        end
        default:
          state <= ST_IDLE;
      endcase
    end
  end

  // Generator steering.
  assign tone1.step = key_en ? bts_dtmf_step(key_digit, rate_alt, 1'b0) // R15
                             : {first_tone_step_high, first_tone_step_low}; // R12
  assign tone2.step = key_en ? bts_dtmf_step(key_digit, rate_alt, 1'b1) // R15
                             : {second_tone_step_high, second_tone_step_low}; // R1 R12
  assign tone1.run  = state == ST_ON;
  assign tone2.run  = state == ST_ON;
  assign tone1.tick = sample_en;
  assign tone2.tick = sample_en;

  bts_tone_gen u_gen1 (
    .aclk    (aclk),
    .aresetn (aresetn),
    .tone    (tone1.gen)
  );

  bts_tone_gen u_gen2 (
    .aclk    (aclk),
    .aresetn (aresetn),
    .tone    (tone2.gen)
  );

  // Halving each term keeps the sum inside 16 bits.
  assign mix_sum = (tone1.sine >>> 1) + (tone2.sine >>> 1);
  assign ramp_w  = 17'sh07fff - {tone1.cosine[15], tone1.cosine};

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      audio_sample <= 16'h0000;
      audio_valid  <= 1'b0;
    end
    else
    begin
      audio_valid <= sample_en;
      if (sample_en)
      begin
        if (state != ST_ON)
          audio_sample <= 16'h0000;
        else
        begin
          case (out_sel)
            OUT_SUM: audio_sample <= mix_sum; // R16
            OUT_ONE: audio_sample <= tone1.sine; // R16
            OUT_TWO: audio_sample <= tone2.sine; // R16
            default: audio_sample <= ramp_w[16:1]; // R16
          endcase
        end
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      tone_active <= 1'b0;
    else
      tone_active <= state == ST_ON;
  end

endmodule // bts_beep_tone_sequencer
`default_nettype wire

// *** testbench/bts_seq_sva.sv ***
`timescale 1ns/100ps
`default_nettype none
module bts_seq_sva
  import bts_pkg::*;
(
  input wire logic        aclk,          // Clock.
  input wire logic        aresetn,       // Reset.
  input wire logic        s_axi_awvalid, // Aw valid.
  input wire logic        s_axi_awready, // Aw ready.
  input wire logic        s_axi_wvalid,  // W valid.
  input wire logic        s_axi_wready,  // W ready.
  input wire logic [1:0]  s_axi_bresp,   // B resp.
  input wire logic        s_axi_bvalid,  // B valid.
  input wire logic        s_axi_bready,  // B ready.
  input wire logic [11:0] s_axi_araddr,  // Ar addr.
  input wire logic        s_axi_arvalid, // Ar valid.
  input wire logic        s_axi_arready, // Ar ready.
  input wire logic [31:0] s_axi_rdata,   // R data.
  input wire logic [1:0]  s_axi_rresp,   // R resp.
  input wire logic        s_axi_rvalid,  // R valid.
  input wire logic        s_axi_rready,  // R ready.
  input wire logic        audio_valid,   // Sample pulse.
  input wire logic        tone_active    // On-phase.
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  property p_wr_answer; s_wr_taken |-> ##[1:2] s_axi_bvalid; endproperty
  a_wr_answer: assert property (p_wr_answer) else $error("write not answered");
  property p_rd_answer; s_rd_taken |=> s_axi_rvalid; endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
  property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped");
  property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped");
  property p_aw_reopen;
    s_axi_bvalid && s_axi_bready |=> s_axi_awready && s_axi_wready && !s_axi_bvalid;
  endproperty
  a_aw_reopen: assert property (p_aw_reopen) else $error("write channel not reopened");
  property p_rd_err;
    s_axi_arvalid && s_axi_arready && (s_axi_araddr[11:2] > IDX_STATUS
      || s_axi_araddr[11:2] < IDX_CFG1 || s_axi_araddr[1:0] != 2'h0)
      |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0;
  endproperty
  a_rd_err: assert property (p_rd_err) else $error("unmapped read not refused");
  property p_rdata_hi; s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0; endproperty
  a_rdata_hi: assert property (p_rdata_hi) else $error("upper read bits set");
  property p_pulse; audio_valid |=> !audio_valid [*8]; endproperty
  a_pulse: assert property (p_pulse) else $error("sample pulse too close");
  property p_on_min; $rose(tone_active) |=> tone_active [*8]; endproperty
  a_on_min: assert property (p_on_min) else $error("on-phase too short");
  property p_off_min; $fell(tone_active) |=> !tone_active [*8]; endproperty
  a_off_min: assert property (p_off_min) else $error("off-phase too short");
endmodule // bts_seq_sva
bind bts_beep_tone_sequencer bts_seq_sva chk_u (.aclk, .aresetn, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
  .s_axi_rready, .audio_valid, .tone_active);
`default_nettype wire

// *** testbench/beep_tone_sequencer_test.sv ***
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin n_fail++; \
  $display("unexpected at %0t: got %h expected %h", $time, a, b); end end
module beep_tone_sequencer_test;
  import bts_pkg::*;
  localparam int         STEP = 20;
  localparam logic [7:0] RV [4] = '{8'h40, 8'h00, 8'h02, 8'h01};
  logic        aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
  logic        arvalid = 0, rready = 0, awready, wready, bvalid, arready, rvalid;
  logic        audio_valid, tone_active;
  logic [11:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata;
  logic [15:0] audio_sample;
  logic [1:0]  bresp, rresp, r;
  logic [7:0]  d, w;
  logic [5:0]  codes [4];
  logic [5:0]  off;
  int          n_fail = 0, n_compared = 0, cyc = 0, beeps = 0, run_len = 0;
  int          last_len = 0, last_rise = 0, prev_rise = 0, b0 = 0;

  always #50 aclk = ~aclk;

  bts_beep_tone_sequencer #(.STEP_CYCLES(STEP)) dut_u (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .audio_sample(audio_sample), .audio_valid(audio_valid), .tone_active(tone_active));

  // Measures each on-phase and the spacing of on-phase starts.
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (tone_active === 1'b1)
    begin
      if (run_len == 0)
      begin
        prev_rise <= last_rise;
        last_rise <= cyc;
      end
      run_len <= run_len + 1;
    end
    else
    begin
      if (run_len != 0)
      begin
        last_len <= run_len;
        beeps <= beeps + 1;
      end
      run_len <= 0;
    end
  end

  function automatic int steps(input logic [5:0] c);
    return (c <= 6'h18) ? int'(c) : 25 + 5 * (int'(c) - 25);
  endfunction

  function automatic int nbeeps(input int k);
    return (k < 4) ? k + 1 : 1 << (k - 1);
  endfunction

  task automatic wr(input logic [9:0] idx, input logic [7:0] v);
    @(posedge aclk);
    awaddr <= {idx, 2'h0};
    wdata <= {24'h0, v};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end
    while (bvalid !== 1'b1);
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [9:0] idx, output logic [7:0] v, output logic [1:0] rs);
    @(posedge aclk);
    araddr <= {idx, 2'h0};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end
    while (rvalid !== 1'b1);
    v = rdata[7:0];
    rs = rresp;
    rready <= 1'b0;
  endtask

  task automatic go(input logic [2:0] rep, input logic [5:0] on_c, input logic [5:0] off_c);
    wr(IDX_REPEAT, {5'h0, rep});
    wr(IDX_ON_TIME, {2'h0, on_c});
    wr(IDX_OFF_TIME, {2'h0, off_c});
    b0 = beeps;
    wr(IDX_CFG1, 8'h80);
  endtask

  task automatic wait_idle;
    do rd(IDX_STATUS, d, r); while (d[7] !== 1'b0);
  endtask

  task automatic complete_run;
    if (n_fail == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial
  begin
    repeat (80000) @(posedge aclk);
    n_fail++;
    complete_run;
  end

  initial
  begin
    void'($urandom(35753));
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      rd(IDX_F2_HI + 10'(i), d, r);
      `CHK(d, RV[i])
    end
    w = 8'($urandom);
    wr(IDX_F2_HI, w);
    rd(IDX_F2_HI, d, r);
    `CHK(d, w)
    rd(10'h0b0, d, r);
    `CHK(r, RESP_SLVERR)
    for (int k = 0; k < 7; k++)
    begin
      go(3'(k), 6'h01, 6'h01);
      wait_idle;
      `CHK(beeps - b0, nbeeps(k))
      `CHK(d[5:0], 6'(nbeeps(k)))
      rd(IDX_CFG1, d, r);
      `CHK(d[7], 1'b0)
    end
    codes = '{6'h14, 6'h19, 6'(1 + $urandom % 20), 6'(25 + $urandom % 8)};
    for (int i = 0; i < 4; i++)
    begin
      off = 6'(1 + $urandom % 20);
      go(3'h1, codes[i], off);
      wait_idle;
      `CHK(last_len, steps(codes[i]) * STEP)
      `CHK(last_rise - prev_rise, (steps(codes[i]) + steps(off)) * STEP)
    end
    go(3'h7, 6'h01, 6'h01);
    while (beeps < b0 + 5) @(posedge aclk);
    wr(IDX_CFG1, 8'h00);
    wait_idle;
    b0 = beeps;
    repeat (100) @(posedge aclk);
    `CHK(beeps - b0, 0)
    go(3'h0, 6'h3f, 6'h01);
    repeat (300) @(posedge aclk);
    `CHK(tone_active, 1'b1)
    wr(IDX_CFG1, 8'h00);
    wait_idle;
    repeat (5) @(posedge aclk);
    `CHK(tone_active, 1'b0)
    wr(IDX_RATE, 8'h01);
    @(posedge aclk iff audio_valid === 1'b1);
    b0 = cyc;
    @(posedge aclk iff audio_valid === 1'b1);
    `CHK(cyc - b0, SR_DIV_ALT)
    `CHK(audio_sample, 16'h0000)
    complete_run;
  end
endmodule // beep_tone_sequencer_test
`default_nettype wire
